// File: logic/ddiwp_pkg.sv
// Purpose: Shared constants and types for the dual DAC two-wire write port.
// Assumes: One 40 MHz system clock; the serial bus is sampled, not clocked.
// Notes:   Every offset, reset value and code lives here once.
`default_nettype none
package ddiwp_pkg;
	// Receiver states of the serial slave.
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ADDR,
		ST_DATA,
		ST_SKIP
	} ddiwp_state_type;

	// The 24-bit input word assembled from the three data bytes.
	typedef struct packed {
		logic [3:0]  command_field;
		logic [3:0]  channel_select_field;
		logic [15:0] data;
	} ddiwp_word_type;

	// Three-state address pin sense codes.
	localparam logic [1:0] PIN_LOW   = 2'h0;
	localparam logic [1:0] PIN_FLOAT = 2'h1;
	localparam logic [1:0] PIN_HIGH  = 2'h2;

	// Hard-wired global slave address, binary 1110011.
	localparam logic [6:0] GLOBAL_ADDR = 7'h73;

	// Command codes of the upper nibble of the first data byte.
	localparam logic [3:0] CMD_WRITE  = 4'h0;
	localparam logic [3:0] CMD_UPDATE = 4'h1;
	localparam logic [3:0] CMD_WR_UPD = 4'h3;
	localparam logic [3:0] CMD_PDOWN  = 4'h4;
	localparam logic [3:0] CMD_NOP    = 4'hf;

	// Channel select codes of the lower nibble.
	localparam logic [3:0] CHAN_A    = 4'h0;
	localparam logic [3:0] CHAN_B    = 4'h1;
	localparam logic [3:0] CHAN_BOTH = 4'hf;

	// Bit and byte counts of the serial frame.
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [1:0] DATA_BYTES    = 2'h3;
	localparam logic [1:0] LAST_BYTE_IDX = 2'h2;

	// Power-on codes for the zero-scale and midscale variants.
	localparam logic [15:0] CODE_ZERO = 16'h0000;
	localparam logic [15:0] CODE_MID  = 16'h8000;

	// APB register byte offsets.
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_CODE_OUT = 8'h08;
	localparam logic [7:0] OFS_CODE_IN  = 8'h0c;

	// Control register: bit 0 lets the slave answer on the bus.
	localparam int         CTRL_EN_BIT   = 0;
	localparam logic [0:0] CTRL_RESET    = 1'h1;
	// Status field positions.
	localparam int STAT_PD_A_BIT  = 0;
	localparam int STAT_PD_B_BIT  = 1;
	localparam int STAT_DONE_BIT  = 2;
	localparam int STAT_BUSY_BIT  = 3;
	localparam int STAT_ADDR_LSB  = 8;

	// Slave address from three pin states: index 9*p2+3*p1+p0, upper
	// three bits index/4+1, two zero bits, low two bits index mod 4.
	function automatic logic [6:0] pin_addr(input logic [1:0] p2,
		input logic [1:0] p1, input logic [1:0] p0);
		logic [4:0] idx;
		idx = {3'h0, p2} * 5'h09 + {3'h0, p1} * 5'h03 + {3'h0, p0};
		return {3'(idx[4:2] + 3'h1), 2'h0, idx[1:0]};
	endfunction
endpackage
`default_nettype wire

// File: logic/ddiwp_top.sv
// Purpose: Receive-only two-wire slave and double-buffered code registers
//          of a two-channel DAC, with an APB window for software.
// Assumes: SCL, SDA, the update pin and address pins are asynchronous and
//          are sampled by mclk_in; SCL is far slower than mclk_in.
// Notes:   SDA is open drain: the pin is pulled low only while acking.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [R1] Codes reset to zero or midscale variant.
// [R2] Receive only; reads are never answered.
// [R3] SDA fall with SCL high starts address.
// [R4] SDA rise with SCL high frees bus.
// [R5] Master clocks and releases each ack bit.
// [R6] Ack holds SDA low through clock high.
// [R7] Read bit gets no acknowledge.
// [R8] Three three-state pins give 27 addresses.
// [R9] Address from pin index, ninths, thirds, units.
// [R10] Global address 1110011 also answered.
// [R11] Address plus write bit acked on match.
// [R12] Three data bytes each acknowledged.
// [R13] Command runs after third byte completes.
// [R14] Surplus data bytes are not acknowledged.
// [R15] First byte: command then channel nibble.
// [R16] Bytes two and three: left-justified code.
// [R17] Write loads selected input register.
// [R18] Update copies input to output register.
// [R19] Any update ends that channel's power-down.
// [R20] Decode write, update, both, powerdown, nop.
// [R21] Channel codes A, B and both.
// [R22] Update pin fall copies after complete word.
// [R23] Bits sampled on SCL rising edges.
// [R24] START or STOP abandons partial transfers.
// [R25] Bus lines synchronised before edge detection.
module ddiwp_top #(
	parameter bit MIDSCALE_VARIANT = 1'b0
) (
	input  wire logic        mclk_in,
	input  wire logic        resetn_in,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output var  logic        sda_out,
	output var  logic        sda_oe_n_out,
	input  wire logic [1:0]  addr_sel_pin_0_in,
	input  wire logic [1:0]  addr_sel_pin_1_in,
	input  wire logic [1:0]  addr_sel_pin_2_in,
	input  wire logic        async_update_n_in,
	output var  logic [15:0] dac_a_code_out,
	output var  logic [15:0] dac_b_code_out,
	output var  logic        dac_a_pd_out,
	output var  logic        dac_b_pd_out,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr
);
	// Power-on code chosen by the variant.
	localparam logic [15:0] RESET_CODE =
		MIDSCALE_VARIANT ? ddiwp_pkg::CODE_MID : ddiwp_pkg::CODE_ZERO;

	// Synchroniser stages: first, second and edge-history flops.
	logic       scl_m_r, scl_s_r, scl_q_r;
	logic       sda_m_r, sda_s_r, sda_q_r;
	logic       upd_m_r, upd_s_r, upd_q_r;
	logic [5:0] pins_m_r, pins_s_r;
	// Receiver state.
	ddiwp_pkg::ddiwp_state_type state_r;
	logic [3:0] bit_cnt_r;        // Bits taken in the current byte.
	logic [7:0] shift_r;          // Byte being shifted in.
	logic       ack_phase_r;      // Inside the ninth clock of a byte.
	logic [1:0] byte_cnt_r;       // Data bytes taken in this frame.
	logic       word_pending_r;   // Third byte acked, command not run.
	logic       word_done_r;      // A complete word has been executed.
	ddiwp_pkg::ddiwp_word_type word_r;
	// Code and power-down registers.
	logic [15:0] in_a_r, in_b_r, out_a_r, out_b_r;
	logic        pd_a_r, pd_b_r;
	// Software enable and open-drain pin drive flops.
	logic        ctrl_en_r, sda_oe_n_r, sda_lvl_r;
	// APB answer flops.
	logic [31:0] prdata_r;
	logic        pready_r, pslverr_r;
	// Decoded events.
	logic        scl_rise, scl_fall, start_det, stop_det;
	logic        upd_fall, upd_low, exec_now, addr_match;
	logic        sel_a, sel_b, cmd_writes, cmd_updates;
	logic [6:0]  own_addr;
	logic [15:0] new_in_a, new_in_b;

	// Two flops on every asynchronous input; only the second stage and
	// the history flop feed logic, so metastability never reaches it.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			{scl_m_r, scl_s_r, scl_q_r} <= 3'h7;
			{sda_m_r, sda_s_r, sda_q_r} <= 3'h7;
			{upd_m_r, upd_s_r, upd_q_r} <= 3'h7;
			pins_m_r <= 6'h00;
			pins_s_r <= 6'h00;
		end else begin
			{scl_m_r, scl_s_r, scl_q_r} <= {scl_in, scl_m_r, scl_s_r}; // [R25]
			{sda_m_r, sda_s_r, sda_q_r} <= {sda_in, sda_m_r, sda_s_r}; // [R25]
			{upd_m_r, upd_s_r, upd_q_r} <= {async_update_n_in, upd_m_r,
				upd_s_r};
			pins_m_r <= {addr_sel_pin_2_in, addr_sel_pin_1_in,
				addr_sel_pin_0_in};
			pins_s_r <= pins_m_r;
		end
	end

	// Edges and bus conditions from synchronised samples only.
	always_comb begin
		scl_rise  = scl_s_r & ~scl_q_r;
		scl_fall  = ~scl_s_r & scl_q_r;
		start_det = scl_s_r & scl_q_r & sda_q_r & ~sda_s_r; // [R3]
		stop_det  = scl_s_r & scl_q_r & ~sda_q_r & sda_s_r; // [R4]
		upd_fall  = ~upd_s_r & upd_q_r;
		upd_low   = ~upd_s_r;
	end

	// Own address from the three-state pins; an unused code reads as high.
	always_comb begin
		logic [1:0] p0, p1, p2;
		p0 = (pins_s_r[1:0] > ddiwp_pkg::PIN_HIGH) ?
			ddiwp_pkg::PIN_HIGH : pins_s_r[1:0];
		p1 = (pins_s_r[3:2] > ddiwp_pkg::PIN_HIGH) ?
			ddiwp_pkg::PIN_HIGH : pins_s_r[3:2];
		p2 = (pins_s_r[5:4] > ddiwp_pkg::PIN_HIGH) ?
			ddiwp_pkg::PIN_HIGH : pins_s_r[5:4];
		own_addr   = ddiwp_pkg::pin_addr(p2, p1, p0); // [R8] [R9]
		addr_match = ctrl_en_r & ((shift_r[7:1] == own_addr) |
			(shift_r[7:1] == ddiwp_pkg::GLOBAL_ADDR)); // [R10] [R11]
	end

	// Serial receiver. START and STOP win over bit handling and throw
	// away any half-built word, so no command runs from a partial frame.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r        <= ddiwp_pkg::ST_IDLE;
			bit_cnt_r      <= 4'h0;
			shift_r        <= 8'h00;
			ack_phase_r    <= 1'b0;
			byte_cnt_r     <= 2'h0;
			word_pending_r <= 1'b0;
			word_r         <= '0;
			sda_oe_n_r     <= 1'b1;
			// The open-drain level never leaves zero: only the enable moves.
			sda_lvl_r      <= 1'b0;
		end else if (start_det || stop_det) begin // [R24]
			// A START opens address reception, a STOP idles the bus.
			state_r        <= start_det ? ddiwp_pkg::ST_ADDR :
				ddiwp_pkg::ST_IDLE; // [R3] [R4]
			bit_cnt_r      <= 4'h0;
			ack_phase_r    <= 1'b0;
			byte_cnt_r     <= 2'h0;
			word_pending_r <= 1'b0;
			sda_oe_n_r     <= 1'b1;
		end else if (state_r != ddiwp_pkg::ST_IDLE) begin
			if (scl_rise && !ack_phase_r &&
				bit_cnt_r != ddiwp_pkg::BITS_PER_BYTE) begin
				// Data is taken on the rising edge, MSB first.
				shift_r   <= {shift_r[6:0], sda_s_r}; // [R23]
				bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
			end
			if (scl_fall && ack_phase_r) begin
				// End of the ninth clock: let go of the line.
				ack_phase_r    <= 1'b0;
				bit_cnt_r      <= 4'h0;
				word_pending_r <= 1'b0;
				sda_oe_n_r     <= 1'b1;
			end else if (scl_fall &&
				bit_cnt_r == ddiwp_pkg::BITS_PER_BYTE) begin
				// Byte complete: decide the acknowledge for clock nine.
				ack_phase_r <= 1'b1;
				case (state_r)
					ddiwp_pkg::ST_ADDR: begin
						// Only a matching write is acked; reads stay high.
						if (addr_match && !shift_r[0]) begin // [R7] [R2]
							sda_oe_n_r <= 1'b0; // [R11] [R6]
							state_r    <= ddiwp_pkg::ST_DATA;
						end else begin
							state_r    <= ddiwp_pkg::ST_SKIP;
						end
					end
					ddiwp_pkg::ST_DATA: begin
						if (byte_cnt_r != ddiwp_pkg::DATA_BYTES) begin
							sda_oe_n_r <= 1'b0; // [R12] [R6]
							word_r     <= ddiwp_pkg::ddiwp_word_type'(
								{word_r[15:0], shift_r}); // [R15] [R16]
							byte_cnt_r <= 2'(byte_cnt_r + 2'h1);
							if (byte_cnt_r == ddiwp_pkg::LAST_BYTE_IDX) begin
								word_pending_r <= 1'b1;
							end
						end
						// Surplus bytes leave the line released.
					end // [R14]
					default: begin
						// Not addressed: clock through, never drive.
					end
				endcase
			end
		end
	end

	// The command runs when the ninth clock of the third byte falls.
	assign exec_now = scl_fall & ack_phase_r & word_pending_r; // [R13]

	// Command and channel decode of the first data byte.
	always_comb begin
		sel_a = (word_r.channel_select_field == ddiwp_pkg::CHAN_A) |
			(word_r.channel_select_field == ddiwp_pkg::CHAN_BOTH); // [R21]
		sel_b = (word_r.channel_select_field == ddiwp_pkg::CHAN_B) |
			(word_r.channel_select_field == ddiwp_pkg::CHAN_BOTH); // [R21]
		cmd_writes = (word_r.command_field == ddiwp_pkg::CMD_WRITE) |
			(word_r.command_field == ddiwp_pkg::CMD_WR_UPD); // [R20]
		cmd_updates = (word_r.command_field == ddiwp_pkg::CMD_UPDATE) |
			(word_r.command_field == ddiwp_pkg::CMD_WR_UPD); // [R20]
		new_in_a = (cmd_writes && sel_a) ? word_r.data : in_a_r;
		new_in_b = (cmd_writes && sel_b) ? word_r.data : in_b_r;
	end

	// A complete word arms the update pin until the next START.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			word_done_r <= 1'b0;
		end else if (exec_now) begin
			word_done_r <= 1'b1;
		end else if (start_det) begin
			word_done_r <= 1'b0;
		end
	end

	// Input and output code registers. An update pin held low while a
	// word completes also pushes the new inputs straight to the outputs.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			in_a_r  <= RESET_CODE; // [R1]
			in_b_r  <= RESET_CODE; // [R1]
			out_a_r <= RESET_CODE; // [R1]
			out_b_r <= RESET_CODE; // [R1]
		end else if (exec_now) begin
			in_a_r <= new_in_a; // [R17]
			in_b_r <= new_in_b; // [R17]
			if (upd_low) begin
				out_a_r <= new_in_a;
				out_b_r <= new_in_b;
			end else if (cmd_updates) begin
				// Write-and-update forwards the fresh data word.
				if (sel_a) begin
					out_a_r <= new_in_a; // [R18]
				end
				if (sel_b) begin
					out_b_r <= new_in_b; // [R18]
				end
			end
		end else if (upd_fall && word_done_r) begin
			out_a_r <= in_a_r; // [R22]
			out_b_r <= in_b_r; // [R22]
		end
	end

	// Power-down flags. The update pin held low wakes both channels and
	// blocks a software power-down, so the pin always has the last say.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pd_a_r <= 1'b0;
			pd_b_r <= 1'b0;
		end else if (upd_low) begin
			pd_a_r <= 1'b0;
			pd_b_r <= 1'b0;
		end else if (exec_now && cmd_updates) begin
			pd_a_r <= pd_a_r & ~sel_a; // [R19]
			pd_b_r <= pd_b_r & ~sel_b; // [R19]
		end else if (exec_now &&
			word_r.command_field == ddiwp_pkg::CMD_PDOWN) begin
			pd_a_r <= pd_a_r | sel_a; // [R20]
			pd_b_r <= pd_b_r | sel_b; // [R20]
		end
	end

	// APB slave: the answer is prepared in the setup cycle, so every
	// access completes in its first access cycle with no wait state.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= psel & ~penable;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
			if (psel && !penable) begin
				case (paddr)
					ddiwp_pkg::OFS_CTRL: begin
						prdata_r[ddiwp_pkg::CTRL_EN_BIT] <= ctrl_en_r;
					end
					ddiwp_pkg::OFS_STATUS: begin
						prdata_r[ddiwp_pkg::STAT_PD_A_BIT] <= pd_a_r;
						prdata_r[ddiwp_pkg::STAT_PD_B_BIT] <= pd_b_r;
						prdata_r[ddiwp_pkg::STAT_DONE_BIT] <= word_done_r;
						prdata_r[ddiwp_pkg::STAT_BUSY_BIT] <=
							(state_r != ddiwp_pkg::ST_IDLE);
						prdata_r[ddiwp_pkg::STAT_ADDR_LSB +: 7] <= own_addr;
					end
					ddiwp_pkg::OFS_CODE_OUT: begin
						prdata_r <= {out_b_r, out_a_r};
					end
					ddiwp_pkg::OFS_CODE_IN: begin
						prdata_r <= {in_b_r, in_a_r};
					end
					default: begin
						// Unmapped words answer with an error.
						pslverr_r <= 1'b1;
					end
				endcase
			end
		end
	end

	// Control register write, taken at the completing access edge.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctrl_en_r <= ddiwp_pkg::CTRL_RESET[0];
		end else if (psel && penable && pready_r && pwrite &&
			paddr == ddiwp_pkg::OFS_CTRL) begin
			ctrl_en_r <= pwdata[ddiwp_pkg::CTRL_EN_BIT];
		end
	end

	// All outputs come straight from flops.
	assign sda_out        = sda_lvl_r;
	assign sda_oe_n_out   = sda_oe_n_r;
	assign dac_a_code_out = out_a_r;
	assign dac_b_code_out = out_b_r;
	assign dac_a_pd_out   = pd_a_r;
	assign dac_b_pd_out   = pd_b_r;
	assign prdata         = prdata_r;
	assign pready         = pready_r;
	assign pslverr        = pslverr_r;

	// Checks on the design's own behaviour.
	default clocking dflt_cb @(posedge mclk_in);
	endclocking
	default disable iff (!resetn_in);

	start_addr_a: assert property (start_det |=> // [R3]
		state_r == ddiwp_pkg::ST_ADDR && bit_cnt_r == 4'h0 && sda_oe_n_r)
		else $error("START did not open address reception");
	stop_idle_a: assert property (stop_det |=> // [R4]
		state_r == ddiwp_pkg::ST_IDLE && sda_oe_n_r && !word_pending_r)
		else $error("STOP did not free the bus");
	ack_hold_a: assert property (!sda_oe_n_r && !scl_fall && // [R6]
		!start_det && !stop_det |=> !sda_oe_n_r)
		else $error("Acknowledge released before clock fell");
	read_nack_a: assert property (scl_fall && !ack_phase_r && // [R7]
		state_r == ddiwp_pkg::ST_ADDR && bit_cnt_r == 4'h8 && shift_r[0]
		|=> sda_oe_n_r [*2])
		else $error("Read request was acknowledged");
	addr_match_a: assert property (scl_fall && !ack_phase_r && // [R11]
		state_r == ddiwp_pkg::ST_ADDR && bit_cnt_r == 4'h8
		|=> !sda_oe_n_r == $past(addr_match && !shift_r[0]))
		else $error("Address acknowledge disagrees with match");
	surplus_nack_a: assert property (scl_fall && !ack_phase_r && // [R14]
		state_r == ddiwp_pkg::ST_DATA && bit_cnt_r == 4'h8 &&
		byte_cnt_r == 2'h3 |=> sda_oe_n_r && byte_cnt_r == 2'h3)
		else $error("Surplus data byte was acknowledged");
	data_ack_a: assert property (scl_fall && !ack_phase_r && // [R12]
		state_r == ddiwp_pkg::ST_DATA && bit_cnt_r == 4'h8 &&
		byte_cnt_r != 2'h3 |=> !sda_oe_n_r && ack_phase_r)
		else $error("Data byte was not acknowledged");
	write_load_a: assert property (exec_now && cmd_writes && sel_a // [R17]
		|=> in_a_r == $past(word_r.data))
		else $error("Write did not load channel A input");
	update_copy_a: assert property (exec_now && !upd_low && // [R18]
		word_r.command_field == ddiwp_pkg::CMD_UPDATE && sel_b
		|=> out_b_r == $past(in_b_r))
		else $error("Update did not copy channel B input");
	out_cause_a: assert property ($changed(out_a_r) |-> // [R18]
		$past(exec_now || (upd_fall && word_done_r)))
		else $error("Channel A output changed without cause");
	wake_a: assert property (exec_now && cmd_updates && sel_a // [R19]
		|=> !pd_a_r)
		else $error("Update left channel A powered down");
	no_partial_a: assert property (exec_now |-> // [R24]
		byte_cnt_r == 2'h3 && state_r == ddiwp_pkg::ST_DATA)
		else $error("Command ran from a partial word");

	full_write_c: cover property (exec_now && cmd_writes);
	global_c: cover property (scl_fall && state_r == ddiwp_pkg::ST_ADDR &&
		bit_cnt_r == 4'h8 && shift_r[7:1] == ddiwp_pkg::GLOBAL_ADDR);
	pin_update_c: cover property (upd_fall && word_done_r);
	surplus_c: cover property (byte_cnt_r == 2'h3 && scl_fall &&
		bit_cnt_r == 4'h8 && !ack_phase_r);
endmodule
`default_nettype wire

// File: verif/ddiwp_bus_master.sv
// Purpose: Behavioural two-wire bus master that writes to the port.
// Assumes: Both lines have pull-ups; one SCL period is 8 mclk (200 ns).
// Notes:   SCL stands high between frames; SDA released reads as high.
`timescale 1ns/1ps
`default_nettype none
module ddiwp_bus_master (
	input  wire logic mclk_in,
	input  wire logic sda_in,
	output var  logic scl_out,
	output var  logic sda_rel_out
);
	// Both lines start released, so the pull-ups keep the bus idle.
	initial begin
		scl_out = 1'b1;
		sda_rel_out = 1'b1;
	end

	// Waits a number of system clock edges.
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
	endtask

	// Start or repeated start: data falls while the clock is high.
	task automatic bus_start();
		if (scl_out === 1'b0) begin
			sda_rel_out <= 1'b1;
			tick(2);
			scl_out <= 1'b1;
			tick(4);
		end
		sda_rel_out <= 1'b0;
		tick(4);
		scl_out <= 1'b0;
		tick(2);
	endtask

	// One bit, set mid low phase and held across the rising edge; the
	// line is read twice in the high phase so a glitchy ack shows high.
	task automatic bus_bit(input logic b, output logic seen);
		sda_rel_out <= b;
		tick(2);
		scl_out <= 1'b1;
		tick(2);
		seen = sda_in;
		tick(2);
		seen = seen | sda_in;
		scl_out <= 1'b0;
		tick(2);
	endtask

	// Eight bits MSB first, then a ninth clock with SDA released.
	task automatic bus_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bus_bit(d[i], s);
		end
		bus_bit(1'b1, s);
		ack = ~s;
	endtask

	// Stop: data rises while the clock is high, then the bus rests.
	task automatic bus_stop();
		sda_rel_out <= 1'b0;
		tick(2);
		scl_out <= 1'b1;
		tick(4);
		sda_rel_out <= 1'b1;
		tick(8);
	endtask
endmodule
`default_nettype wire

// File: verif/ddiwp_tb.sv
// Purpose: Self-checking bench for the two-wire write port and its APB.
// Assumes: Zero-scale variant; update pin idles high.
// Notes:   Expected codes come from a small model kept in this bench.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        mclk = 1'b0;      // System clock, 40 MHz.
	logic        resetn = 1'b0;    // Asynchronous reset, active low.
	logic        upd_n = 1'b1;     // Update pin, idle high.
	logic [1:0]  p0 = 2'h0;        // Address pin states.
	logic [1:0]  p1 = 2'h0;
	logic [1:0]  p2 = 2'h0;
	logic        psel = 1'b0;      // APB request lines.
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, scl, sda_rel, sda_o, sda_oe_n;
	logic [15:0] code_a, code_b;
	logic        pd_a, pd_b;
	wire  logic  sda_line;         // Open-drain wire with pull-up.
	int          bad_count = 0;
	int          n_compared = 0;
	int          seed = 32'h502030e8;
	logic [15:0] ia, ib, oa, ob;   // Expected input and output codes.
	logic        ea, eb;           // Expected power-down flags.
	localparam logic [3:0] CMDS [6] = '{ddiwp_pkg::CMD_PDOWN,
		ddiwp_pkg::CMD_WRITE, ddiwp_pkg::CMD_UPDATE, ddiwp_pkg::CMD_WR_UPD,
		ddiwp_pkg::CMD_NOP, 4'h7};
	localparam logic [3:0] CHANS [4] = '{ddiwp_pkg::CHAN_A,
		ddiwp_pkg::CHAN_B, ddiwp_pkg::CHAN_BOTH, 4'h5};

	// Low wins on the wire: either party pulling down makes it 0.
	assign sda_line = sda_rel & (sda_oe_n | sda_o);

	// Free-running system clock.
	always #12.5 mclk = ~mclk;

	ddiwp_top uut (.mclk_in(mclk), .resetn_in(resetn), .scl_in(scl),
		.sda_in(sda_line), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
		.addr_sel_pin_0_in(p0), .addr_sel_pin_1_in(p1),
		.addr_sel_pin_2_in(p2), .async_update_n_in(upd_n),
		.dac_a_code_out(code_a), .dac_b_code_out(code_b),
		.dac_a_pd_out(pd_a), .dac_b_pd_out(pd_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	ddiwp_bus_master master (.mclk_in(mclk), .sda_in(sda_line),
		.scl_out(scl), .sda_rel_out(sda_rel));

	// Ends the run with the verdict.
	task automatic print_verdict();
		if (bad_count == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Counts a comparison and reports a difference at once.
	task automatic chk(input string n, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	// Slave address from pin states: ninths, thirds and units.
	function automatic logic [6:0] exp_addr(input logic [1:0] a2, a1, a0);
		int i;
		i = 9 * a2 + 3 * a1 + a0;
		return {3'(i / 4 + 1), 2'h0, 2'(i % 4)};
	endfunction

	// One APB transfer; the request is held until pready is sampled.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		for (int k = 0; k < 16; k++) begin
			@(posedge mclk);
			if (pready === 1'b1) break;
		end
		chk("pready", 32'h1, {31'h0, pready});
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Expected effect of one executed word on the model.
	task automatic model(input logic [3:0] c, h, input logic [15:0] d);
		logic sa, sb;
		sa = (h == ddiwp_pkg::CHAN_A || h == ddiwp_pkg::CHAN_BOTH);
		sb = (h == ddiwp_pkg::CHAN_B || h == ddiwp_pkg::CHAN_BOTH);
		if (c == ddiwp_pkg::CMD_WRITE || c == ddiwp_pkg::CMD_WR_UPD) begin
			ia = sa ? d : ia;
			ib = sb ? d : ib;
		end
		if (c == ddiwp_pkg::CMD_UPDATE || c == ddiwp_pkg::CMD_WR_UPD) begin
			{oa, ea} = sa ? {ia, 1'b0} : {oa, ea};
			{ob, eb} = sb ? {ib, 1'b0} : {ob, eb};
		end
		if (c == ddiwp_pkg::CMD_PDOWN) begin
			ea = ea | sa;
			eb = eb | sb;
		end
	endtask

	// Compares both channels' outputs, flags and input registers.
	task automatic check_outs();
		logic [31:0] r;
		logic        e;
		repeat (8) @(posedge mclk);
		chk("code_a", {16'h0, oa}, {16'h0, code_a});
		chk("code_b", {16'h0, ob}, {16'h0, code_b});
		chk("pd", {30'h0, ea, eb}, {30'h0, pd_a, pd_b});
		chk("sda_out", 32'h0, {31'h0, sda_o});
		apb(1'b0, ddiwp_pkg::OFS_CODE_IN, 32'h0, r, e);
		chk("code_in", {ib, ia}, r);
	endtask

	// START, address byte, nb data bytes from the top of w, STOP.
	task automatic frame(input logic [6:0] a, input logic rw,
		input logic [31:0] w, input int nb, output logic [4:0] ak);
		logic k;
		ak = 5'h0;
		master.bus_start();
		master.bus_byte({a, rw}, k);
		ak[0] = k;
		for (int i = 1; i <= nb; i++) begin
			master.bus_byte(w[8 * (4 - i) +: 8], k);
			ak[i] = k;
		end
		master.bus_stop();
	endtask

	// Main sequence: reset, registers, command sweep and corner cases.
	initial begin
		logic [31:0] r;
		logic        e;
		logic [4:0]  ak;
		logic [15:0] d;
		logic [6:0]  own;
		{ia, ib, oa, ob, ea, eb} = '0;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		repeat (4) @(posedge mclk);
		chk("sda_oe_n", 32'h1, {31'h0, sda_oe_n});
		check_outs();
		apb(1'b0, ddiwp_pkg::OFS_CTRL, 32'h0, r, e);
		chk("ctrl", 32'h1, r);
		apb(1'b1, 8'h40, 32'h1, r, e);
		chk("pslverr", 32'h1, {31'h0, e});
		apb(1'b1, ddiwp_pkg::OFS_STATUS, 32'hffffffff, r, e);
		apb(1'b0, ddiwp_pkg::OFS_STATUS, 32'h0, r, e);
		chk("own_addr", {25'h0, exp_addr(p2, p1, p0)},
			{25'h0, r[14:8]});
		// Every command against every channel code, random pins and data.
		foreach (CMDS[c]) foreach (CHANS[h]) begin
			@(posedge mclk);
			p0 <= 2'($unsigned($random(seed)) % 3);
			p1 <= 2'($unsigned($random(seed)) % 3);
			p2 <= 2'($unsigned($random(seed)) % 3);
			repeat (4) @(posedge mclk);
			d = 16'($random(seed));
			own = ($random(seed) & 1) ? ddiwp_pkg::GLOBAL_ADDR
				: exp_addr(p2, p1, p0);
			frame(own, 1'b0, {CMDS[c], CHANS[h], d, 8'h5a}, 3 + h % 2, ak);
			chk("acks", 32'hf, {27'h0, ak});
			model(CMDS[c], CHANS[h], d);
			check_outs();
		end
		own = exp_addr(p2, p1, p0);
		frame(own ^ 7'h04, 1'b0, 32'h3f123400, 3, ak);
		chk("acks", 32'h0, {27'h0, ak});
		frame(own, 1'b1, 32'h3f567800, 3, ak);
		chk("acks", 32'h0, {27'h0, ak});
		frame(own, 1'b0, 32'h3f9abc00, 2, ak);
		chk("acks", 32'h7, {27'h0, ak});
		check_outs();
		apb(1'b1, ddiwp_pkg::OFS_CTRL, 32'h0, r, e);
		frame(own, 1'b0, 32'h3f0f0f00, 3, ak);
		chk("acks", 32'h0, {27'h0, ak});
		check_outs();
		apb(1'b1, ddiwp_pkg::OFS_CTRL, 32'h1, r, e);
		frame(own, 1'b0, 32'h0fc3a500, 3, ak);
		model(ddiwp_pkg::CMD_WRITE, ddiwp_pkg::CHAN_BOTH, 16'hc3a5);
		check_outs();
		@(posedge mclk);
		upd_n <= 1'b0;
		repeat (4) @(posedge mclk);
		upd_n <= 1'b1;
		{oa, ob, ea, eb} = {ia, ib, 2'b00};
		check_outs();
		// Pin held low while words complete: the outputs follow the
		// fresh write at once, and a software power-down is refused.
		upd_n <= 1'b0;
		frame(own, 1'b0, 32'h0f123400, 3, ak);
		model(ddiwp_pkg::CMD_WRITE, ddiwp_pkg::CHAN_BOTH, 16'h1234);
		{oa, ob} = {ia, ib};
		check_outs();
		frame(own, 1'b0, 32'h4f000000, 3, ak);
		check_outs();
		print_verdict();
	end

	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (60000) @(posedge mclk);
		bad_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
